// ===== igb_pkg.sv
// package for the input deserializer gearbox: modes, widths, carriers
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package igb_pkg;

    // operating modes of the gearbox
    typedef enum logic [1:0]
    {
        igb_video_one_to_seven,
        generic_one_to_eight_mode,
        generic_one_to_four_mode
    } igb_mode_type;

    // word geometry
    localparam int WORD_W = 8;
    localparam int CNT_W = 3;
    localparam int HALF_W = 4;
    localparam int LANES = 2;
    // enabled clocks before the edge stage holds real pin samples
    localparam int FILL_STAGES = 3;

    // last bit index of a word per mode
    localparam logic [CNT_W-1:0] LAST_VIDEO = 3'h6;
    localparam logic [CNT_W-1:0] LAST_DDR8 = 3'h7;
    localparam logic [CNT_W-1:0] LAST_SPLIT = 3'h3;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

    // serial pins coming from outside the clock domain
    typedef struct packed
    {
        logic edge_clk;
        logic data_a;
        logic data_b;
    } igb_serial_type;

    // parallel word handed to the core
    typedef struct packed
    {
        logic valid;
        logic [WORD_W-1:0] data;
    } igb_word_type;

endpackage : igb_pkg

// ===== igb_gearbox.sv
// input deserializer gearbox: edge capture, word alignment, core word output
`timescale 1ns/100ps
`default_nettype none

module igb_gearbox
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // serial pins: fast edge clock and two data lines
    input wire logic fast_edge_clocks,
    input wire logic serial_data_a,
    input wire logic serial_data_b,
    // core controls
    input wire igb_pkg::igb_mode_type mode_sel,
    input wire logic word_align_request,
    // parallel word to the core
    output var igb_pkg::igb_word_type word_out_q
);

    //--------------------------------------------------------------------------
    // decoding helpers
    //--------------------------------------------------------------------------

    // last bit index of a lane's word; lane 1 only works in split mode
    function automatic logic [igb_pkg::CNT_W-1:0] lane_last(input igb_pkg::igb_mode_type m, input int lane);
        logic [igb_pkg::CNT_W-1:0] r;
        r = igb_pkg::LAST_SPLIT;
        if (m == igb_pkg::generic_one_to_eight_mode)
            r = igb_pkg::LAST_DDR8;
        else if (m == igb_pkg::igb_video_one_to_seven)
            r = igb_pkg::LAST_VIDEO;
        return (lane == 0) ? r : igb_pkg::LAST_SPLIT;
    endfunction : lane_last

    // is a lane running in this mode
    function automatic logic lane_on(input igb_pkg::igb_mode_type m, input int lane);
        return (lane == 0) || (m == igb_pkg::generic_one_to_four_mode);
    endfunction : lane_on

    //--------------------------------------------------------------------------
    // pin synchroniser and link edge detection
    //--------------------------------------------------------------------------
    igb_pkg::igb_serial_type pins_in;
    igb_pkg::igb_serial_type sync1_q;
    igb_pkg::igb_serial_type sync2_q;
    igb_pkg::igb_serial_type prev_q;
    logic req_prev_q;

    assign pins_in = '{edge_clk: fast_edge_clocks, data_a: serial_data_a, data_b: serial_data_b};

    // two flops per pin, then one more stage for edge finding
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            req_prev_q <= 1'b0;
        end
        else if (clock_enable)
        begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            req_prev_q <= word_align_request;
        end
    end

    // the chain refills after reset; until then a stage difference is only
    // the cleared value meeting a high pin, not a real link edge
    logic [igb_pkg::FILL_STAGES-1:0] fill_q;
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            fill_q <= '0;
        else if (clock_enable)
            fill_q <= {fill_q[igb_pkg::FILL_STAGES-2:0], 1'b1};
    end
    wire chain_full = fill_q[igb_pkg::FILL_STAGES-1];

    // either edge of the link clock gives one bit; data is taken from the
    // sample just before the edge, where it has settled
    wire link_rise = sync2_q.edge_clk & ~prev_q.edge_clk;
    wire link_fall = ~sync2_q.edge_clk & prev_q.edge_clk;
    wire bit_strobe = clock_enable & chain_full & (link_rise | link_fall);
    wire [igb_pkg::LANES-1:0] lane_bit = {prev_q.data_b, prev_q.data_a};
    wire align_rise = clock_enable & word_align_request & ~req_prev_q;

    //--------------------------------------------------------------------------
    // per-lane capture and alignment stages
    //--------------------------------------------------------------------------
    logic [igb_pkg::WORD_W-1:0] shift_q [igb_pkg::LANES];
    logic [igb_pkg::WORD_W-1:0] aligned_q [igb_pkg::LANES];
    logic [igb_pkg::CNT_W-1:0] cnt_q [igb_pkg::LANES];
    logic [igb_pkg::LANES-1:0] slip_q;
    logic [igb_pkg::LANES-1:0] update_q;
    logic [igb_pkg::CNT_W-1:0] align_select_ctrl_q;

    generate
        for (genvar ln = 0; ln < igb_pkg::LANES; ln++)
        begin : g_lane
            wire active = lane_on(mode_sel, ln);
            wire take = bit_strobe & active;
            wire at_last = (cnt_q[ln] == lane_last(mode_sel, ln));
            wire word_done = take & at_last & ~slip_q[ln];
            wire [igb_pkg::CNT_W-1:0] cnt_next = at_last ? igb_pkg::CNT_ZERO : cnt_q[ln] + igb_pkg::CNT_ONE;

            // first stage: newest bit enters at bit 0
            always_ff @(posedge clock)
            begin
                if (!reset_n)
                    shift_q[ln] <= '0;
                else if (take)
                    shift_q[ln] <= {shift_q[ln][igb_pkg::WORD_W-2:0], lane_bit[ln]};
            end

            // second stage: a pending slip holds the count for one bit,
            // moving the boundary; a new request beats the clear
            always_ff @(posedge clock)
            begin
                if (!reset_n)
                begin
                    cnt_q[ln] <= igb_pkg::CNT_ZERO;
                    slip_q[ln] <= 1'b0;
                    update_q[ln] <= 1'b0;
                    aligned_q[ln] <= '0;
                end
                else if (clock_enable)
                begin
                    slip_q[ln] <= (align_rise & active) | (slip_q[ln] & ~take);
                    update_q[ln] <= word_done;
                    if (!active)
                        cnt_q[ln] <= igb_pkg::CNT_ZERO;
                    else if (take && !slip_q[ln])
                        cnt_q[ln] <= cnt_next;
                    if (word_done)
                        aligned_q[ln] <= {shift_q[ln][igb_pkg::WORD_W-2:0], lane_bit[ln]};
                end
            end
        end
    endgenerate

    // select control: running count of boundary slips within a word
    wire sel_wrap = (align_select_ctrl_q == lane_last(mode_sel, 0));
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            align_select_ctrl_q <= igb_pkg::CNT_ZERO;
        else if (align_rise)
            align_select_ctrl_q <= sel_wrap ? igb_pkg::CNT_ZERO : align_select_ctrl_q + igb_pkg::CNT_ONE;
    end

    //--------------------------------------------------------------------------
    // third stage: word onto the system clock
    //--------------------------------------------------------------------------
    wire split = (mode_sel == igb_pkg::generic_one_to_four_mode);
    wire video = (mode_sel == igb_pkg::igb_video_one_to_seven);
    wire [igb_pkg::WORD_W-1:0] word_map =
        split ? {aligned_q[0][igb_pkg::HALF_W-1:0], aligned_q[1][igb_pkg::HALF_W-1:0]} :
        video ? {1'b0, aligned_q[0][igb_pkg::WORD_W-2:0]} : aligned_q[0];
    wire word_ready = split ? |update_q : update_q[0];

    // the word only moves when a new one is complete, so the core sees it stable
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            word_out_q <= '0;
        else if (clock_enable)
        begin
            word_out_q.valid <= word_ready;
            if (word_ready)
                word_out_q.data <= word_map;
        end
    end

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    // lane 0 word end, seen from outside the generate scope
    wire at_last0 = (cnt_q[0] == lane_last(mode_sel, 0));

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_word_done;
        clock_enable && update_q[0];
    endsequence

    sequence s_word_out;
        word_out_q.valid;
    endsequence

    sequence s_slip_take;
        bit_strobe && slip_q[0];
    endsequence

    a_lane_idle: assert property (!split && clock_enable |=> cnt_q[1] == igb_pkg::CNT_ZERO)
        else $error("second lane counts outside split mode");
    a_video_width: assert property (word_out_q.valid && video |-> !word_out_q.data[igb_pkg::WORD_W-1])
        else $error("video word uses bit 7");
    a_split_halves: assert property (word_out_q.valid && split |->
        word_out_q.data == {$past(aligned_q[0][igb_pkg::HALF_W-1:0]), $past(aligned_q[1][igb_pkg::HALF_W-1:0])})
        else $error("split halves misplaced");
    a_pipe_order: assert property (s_word_done |=> s_word_out)
        else $error("aligned word did not reach the output");
    a_both_edges: assert property (bit_strobe && link_fall |=> shift_q[0][0] == $past(prev_q.data_a))
        else $error("falling edge bit not captured");
    a_update_cause: assert property (update_q[0] && $past(clock_enable) |-> $past(bit_strobe && at_last0 && !slip_q[0]))
        else $error("update without a completed word");
    a_select_step: assert property (align_rise && !sel_wrap |=> align_select_ctrl_q == $past(align_select_ctrl_q) + igb_pkg::CNT_ONE)
        else $error("select control did not step");
    a_word_hold: assert property (!$stable(word_out_q.data) |-> word_out_q.valid)
        else $error("word changed without a new word");
    a_reset_clear: assert property (disable iff (1'b0) !reset_n |=> word_out_q == '0 && slip_q == '0)
        else $error("reset left output or alignment set");
    a_slip_hold: assert property (s_slip_take |=> cnt_q[0] == $past(cnt_q[0]))
        else $error("pending slip did not hold the bit count");
    a_enable_freeze: assert property (!clock_enable |=> $stable(word_out_q) && $stable(cnt_q[0]))
        else $error("state moved while clock enable was low");

endmodule : igb_gearbox

`default_nettype wire

// ===== igb_serial_source.sv
// serial link source model driving the gearbox pins
`timescale 1ns/100ps
`default_nettype none

module igb_serial_source
(
    // serial pins toward the gearbox
    output var igb_pkg::igb_serial_type serial_q
);
    logic busy = 1'b0;

    // idle data flips so a stale bit never passes for a good one
    initial
    begin
        serial_q = '0;
        forever
        begin
            #20;
            if (!busy)
                serial_q[1:0] = ~serial_q[1:0];
        end
    end

    // msb first; data held 40 ns on each side of a link edge
    task automatic send(input logic [15:0] a, input logic [15:0] b, input int n);
        busy = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_q.data_a = a[i];
            serial_q.data_b = b[i];
            #40;
            serial_q.edge_clk = ~serial_q.edge_clk;
            #40;
        end
        busy = 1'b0;
    endtask : send
endmodule : igb_serial_source

`default_nettype wire

// ===== input_deserializer_gearbox_tb.sv
// self-checking bench for the input deserializer gearbox
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module input_deserializer_gearbox_tb;
    logic clock;
    logic reset_n;
    logic clock_enable;
    logic word_align_request;
    igb_pkg::igb_mode_type mode_sel;
    igb_pkg::igb_serial_type serial;
    igb_pkg::igb_word_type word_out_q;
    logic [7:0] expect_q[$];
    logic [7:0] exp_w;
    logic [15:0] lfsr_q;
    int miscompares = 0;
    int tests_run = 0;

    igb_gearbox igb_gearbox_i (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
        .fast_edge_clocks(serial.edge_clk), .serial_data_a(serial.data_a), .serial_data_b(serial.data_b),
        .mode_sel(mode_sel), .word_align_request(word_align_request), .word_out_q(word_out_q));
    igb_serial_source igb_serial_source_i (.serial_q(serial));

    // 50 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // watcher: every valid word takes the oldest note; sampled mid-cycle
    always @(negedge clock)
        if (word_out_q.valid === 1'b1)
        begin
            exp_w = (expect_q.size() != 0) ? expect_q.pop_front() : 8'hXX;
            `CHK("word_out", exp_w, word_out_q.data)
        end

    task automatic report_and_stop;
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // bounded wait for the pipeline to hand over the noted word
    task automatic settle;
        for (int i = 0; i < 20 && expect_q.size() != 0; i++)
            tick(1);
        if (expect_q.size() != 0)
        begin
            `CHK("word_timeout", 1'b0, 1'b1)
            report_and_stop();
        end
    endtask : settle

    task automatic word(input logic [15:0] a, input logic [15:0] b, input int n, input logic [7:0] e);
        expect_q.push_back(e);
        igb_serial_source_i.send(a, b, n);
        settle();
    endtask : word

    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step

    // main sequence: every mode, a slip, a reset mid-frame
    initial
    begin
        clock_enable = 1'b1;
        reset_n = 1'b0;
        word_align_request = 1'b0;
        mode_sel = igb_pkg::igb_video_one_to_seven;
        lfsr_q = 16'h0298;
        tick(4);
        reset_n = 1'b1;
        tick(2);
        for (int k = 0; k < 3; k++)
        begin
            lfsr_q = lfsr_step(lfsr_q);
            word({9'h000, lfsr_q[6:0]}, lfsr_q, 7, {1'b0, lfsr_q[6:0]});
        end
        mode_sel = igb_pkg::generic_one_to_eight_mode;
        for (int k = 0; k < 3; k++)
        begin
            lfsr_q = lfsr_step(lfsr_q);
            word(lfsr_q, ~lfsr_q, 8, lfsr_q[7:0]);
        end
        // a request while frozen is not seen, so the next word keeps its boundary
        clock_enable = 1'b0;
        word_align_request = 1'b1;
        tick(2);
        word_align_request = 1'b0;
        tick(1);
        clock_enable = 1'b1;
        word(16'h005A, 16'h0000, 8, 8'h5A);
        mode_sel = igb_pkg::generic_one_to_four_mode;
        for (int k = 0; k < 3; k++)
        begin
            lfsr_q = lfsr_step(lfsr_q);
            word(lfsr_q >> 4, lfsr_q, 4, lfsr_q[7:0]);
        end
        mode_sel = igb_pkg::generic_one_to_eight_mode;
        tick(1);
        word_align_request = 1'b1;
        tick(1);
        word_align_request = 1'b0;
        tick(1);
        lfsr_q = lfsr_step(lfsr_q);
        word(lfsr_q, 16'h0000, 9, lfsr_q[7:0]);
        word(16'h00A5, 16'h0000, 8, 8'hA5);
        // three bits leave the link clock high, then reset: no word may leak
        // out and the high pin must not pass for an edge after release
        igb_serial_source_i.send(16'h0007, 16'h0000, 3);
        reset_n = 1'b0;
        tick(2);
        `CHK("reset_word", 9'h000, word_out_q)
        reset_n = 1'b1;
        tick(1);
        `CHK("released_word", 9'h000, word_out_q)
        word(16'h003C, 16'h0000, 8, 8'h3C);
        report_and_stop();
    end
endmodule : input_deserializer_gearbox_tb

`default_nettype wire
